// ---- core/bfg_top.sv ----
`include "bfg_defs.svh"

module bfg_top
  import bfg_pkg::*;
#(
  parameter int FADE_SLOW_CYC =
    `BFG_FADE_SLOW_NS / `BFG_CLK_NS / `BFG_FADE_STEPS,
  parameter int FADE_FAST_CYC =
    `BFG_FADE_FAST_NS / `BFG_CLK_NS / `BFG_FADE_STEPS
) (
  input  wire logic                   clk,       // 200 MHz clock
  input  wire logic                   rst_n,     // Sync reset, active low
  input  wire logic                   scl_i,     // Serial clock pin
  input  wire logic                   sda_i,     // Serial data pin level
  output logic                        sda_o,     // Serial data drive level
  output logic                        sda_oe_n,  // Low while pulling SDA
  input  wire logic [`BFG_GPIO_N-1:0] gpio_i,    // GPIO pin levels
  output logic      [`BFG_GPIO_N-1:0] gpio_o,    // GPIO drive levels
  output logic      [`BFG_GPIO_N-1:0] gpio_oe_n, // Low while driving pin
  output bfg_sink_t                   main_sink, // Main sink enable, code
  output bfg_sink_t                   sub_sink   // Secondary sink
);

  // Pin synchronisers; stage 1 feeds stage 2 only
  logic                   scl_s1, scl_s2, scl_s3;
  logic                   sda_s1, sda_s2, sda_s3;
  logic [`BFG_GPIO_N-1:0] gpio_s1, gpio_s2;

  // Link state
  bfg_link_st_t st_q;
  logic [3:0]   cnt_q;
  logic [7:0]   shift_q;
  logic [7:0]   ptr_q;
  logic         drive_q;
  logic         nack_q;
  logic         wr_q;
  logic [7:0]   wr_addr_q;
  logic [7:0]   wr_data_q;
  logic         scl_rise, scl_fall, start_det, stop_det;
  logic [7:0]   rd_cur;

  // Register file
  logic [7:0] ctrl_q;
  logic [7:0] main_cur_q;
  logic [7:0] sub_cur_q;
  logic [7:0] gdir_q;
  logic [7:0] gdat_q;
  logic [7:0] pwm_q;

  // Fade and gating
  logic [7:0] main_code, sub_code;
  logic       pwm_lvl;
  logic       main_gate, sub_gate;

  // Register read decode
  function automatic logic [7:0] rd_byte(input logic [7:0] a);
    case (a)
      `BFG_A_CTRL:     rd_byte = ctrl_q;
      `BFG_A_MAIN_CUR: rd_byte = main_cur_q;
      `BFG_A_SUB_CUR:  rd_byte = sub_cur_q;
      `BFG_A_GPIO_DIR: rd_byte = gdir_q;
      `BFG_A_GPIO_DAT: rd_byte = {5'h00, gpio_s2};
      `BFG_A_PWM_EN:   rd_byte = pwm_q;
      default:         rd_byte = 8'h00;
    endcase
  endfunction

  // Write strobe decode
  function automatic logic hit(input logic [7:0] a);
    hit = wr_q && (wr_addr_q == a);
  endfunction

  // Byte under the pointer; its top bit goes out first on a read
  assign rd_cur = rd_byte(ptr_q);

  // Two flops on every pin, plus a third on the link for edges
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
    end else begin
      scl_s1 <= scl_i;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= sda_i;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
    end
  end

  // GPIO sampling also feeds the PWM gate
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gpio_s1 <= '0;
      gpio_s2 <= '0;
    end else begin
      gpio_s1 <= gpio_i;
      gpio_s2 <= gpio_s1;
    end
  end

  // Bus events, from synchronised levels only
  assign scl_rise  = scl_s2 && !scl_s3;
  assign scl_fall  = !scl_s2 && scl_s3;
  assign start_det = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
  assign stop_det  = scl_s2 && scl_s3 && !sda_s3 && sda_s2;

  // Link state machine; start and stop win over any bit activity
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q    <= BFG_IDLE;
      cnt_q   <= 4'h0;
      shift_q <= 8'h00;
      ptr_q   <= 8'h00;
      drive_q <= 1'b0;
      nack_q  <= 1'b0;
    end else if (start_det) begin
      st_q    <= BFG_ADDR;
      cnt_q   <= 4'h0;
      drive_q <= 1'b0;
    end else if (stop_det) begin
      st_q    <= BFG_IDLE;
      drive_q <= 1'b0;
    end else begin
      unique case (st_q)
        BFG_IDLE: begin
        end
        BFG_ADDR, BFG_REG, BFG_WDATA: begin
          if (scl_rise && cnt_q != 4'h8) begin
            shift_q <= {shift_q[6:0], sda_s2};
            cnt_q   <= cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == 4'h8) begin
            cnt_q <= 4'h0;
            if (st_q == BFG_ADDR) begin
              if (shift_q[7:1] == `BFG_DEV_ADDR) begin
                nack_q  <= shift_q[0];  // Holds read flag until ack ends
                drive_q <= 1'b1;
                st_q    <= BFG_ADDR_ACK;
              end else begin
                st_q <= BFG_IDLE;
              end
            end else if (st_q == BFG_REG) begin
              ptr_q   <= shift_q;
              drive_q <= 1'b1;
              st_q    <= BFG_REG_ACK;
            end else begin
              drive_q <= 1'b1;
              st_q    <= BFG_WDATA_ACK;
            end
          end
        end
        BFG_ADDR_ACK: begin
          if (scl_fall && nack_q) begin
            shift_q <= rd_cur;
            drive_q <= !rd_cur[7];
            cnt_q   <= 4'h0;
            st_q    <= BFG_RDATA;
          end else if (scl_fall) begin
            drive_q <= 1'b0;
            st_q    <= BFG_REG;
          end
        end
        BFG_REG_ACK: begin
          if (scl_fall) begin
            drive_q <= 1'b0;
            st_q    <= BFG_WDATA;
          end
        end
        BFG_WDATA_ACK: begin
          if (scl_fall) begin
            drive_q <= 1'b0;
            ptr_q   <= ptr_q + 8'h01;   // Burst writes walk upward
            st_q    <= BFG_WDATA;
          end
        end
        BFG_RDATA: begin
          if (scl_fall && cnt_q == 4'h7) begin
            drive_q <= 1'b0;
            ptr_q   <= ptr_q + 8'h01;
            st_q    <= BFG_RDATA_ACK;
          end else if (scl_fall) begin
            shift_q <= {shift_q[6:0], 1'b0};
            drive_q <= !shift_q[6];
            cnt_q   <= cnt_q + 4'h1;
          end
        end
        BFG_RDATA_ACK: begin
          if (scl_rise) begin
            nack_q <= sda_s2;
          end else if (scl_fall && nack_q) begin
            st_q <= BFG_IDLE;           // Master ends the read
          end else if (scl_fall) begin
            shift_q <= rd_cur;
            drive_q <= !rd_cur[7];
            cnt_q   <= 4'h0;
            st_q    <= BFG_RDATA;
          end
        end
        default: begin
          st_q <= BFG_IDLE;
        end
      endcase
    end
  end

  // Open-drain data: only ever pulls low
  assign sda_o    = 1'b0;
  assign sda_oe_n = !drive_q;

  // Commit on the rising clock of each data ack, one cycle strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_q      <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
    end else begin
      wr_q      <= (st_q == BFG_WDATA_ACK) && scl_rise
                   && !start_det && !stop_det;
      wr_addr_q <= ptr_q;
      wr_data_q <= shift_q;
    end
  end

  // Backlight control; upper bits read back as zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q <= `BFG_RST_BYTE;
    end else if (hit(`BFG_A_CTRL)) begin
      ctrl_q <= {2'b00, wr_data_q[5:0]};
    end
  end

  // Current codes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      main_cur_q <= `BFG_RST_BYTE;
      sub_cur_q  <= `BFG_RST_BYTE;
    end else begin
      if (hit(`BFG_A_MAIN_CUR)) begin
        main_cur_q <= wr_data_q;
      end
      if (hit(`BFG_A_SUB_CUR)) begin
        sub_cur_q <= wr_data_q;
      end
    end
  end

  // GPIO direction, data and external PWM enables
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gdir_q <= `BFG_RST_BYTE;
      gdat_q <= `BFG_RST_BYTE;
      pwm_q  <= `BFG_RST_BYTE;
    end else begin
      if (hit(`BFG_A_GPIO_DIR)) begin
        gdir_q <= {3'b000, wr_data_q[4], 1'b0, wr_data_q[2:0]};
      end
      if (hit(`BFG_A_GPIO_DAT)) begin
        gdat_q <= {5'h00, wr_data_q[2:0]};
      end
      if (hit(`BFG_A_PWM_EN)) begin
        pwm_q <= {6'h00, wr_data_q[1:0]};
      end
    end
  end

  // Fade engines; the sequence order is software's duty
  bfg_fade #(
    .SLOW_CYC (FADE_SLOW_CYC),
    .FAST_CYC (FADE_FAST_CYC)
  ) u_fade_main (
    .clk     (clk),
    .rst_n   (rst_n),
    .target  (main_cur_q),
    .ramp_en (ctrl_q[`BFG_B_FADE_EN] && !ctrl_q[`BFG_B_FADE_SEL]),
    .fast    (ctrl_q[`BFG_B_SLOPE]),
    .code_q  (main_code)
  );

  bfg_fade #(
    .SLOW_CYC (FADE_SLOW_CYC),
    .FAST_CYC (FADE_FAST_CYC)
  ) u_fade_sub (
    .clk     (clk),
    .rst_n   (rst_n),
    .target  (sub_cur_q),
    .ramp_en (ctrl_q[`BFG_B_FADE_EN] && ctrl_q[`BFG_B_FADE_SEL]),
    .fast    (ctrl_q[`BFG_B_SLOPE]),
    .code_q  (sub_code)
  );

  // PWM gate only counts when GPIO 0 is the PWM input
  assign pwm_lvl   = gpio_s2[0];
  assign main_gate = !(pwm_q[`BFG_B_PWM_MAIN] && gdir_q[`BFG_B_PWM_PIN])
                     || pwm_lvl;
  assign sub_gate  = !(pwm_q[`BFG_B_PWM_SUB] && gdir_q[`BFG_B_PWM_PIN])
                     || pwm_lvl;

  // Registered sink drive; code is 0.1 mA per count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      main_sink <= '0;
      sub_sink  <= '0;
    end else begin
      main_sink.en   <= ctrl_q[`BFG_B_MAIN_EN] && main_gate;
      main_sink.code <= main_code;
      sub_sink.en    <= ctrl_q[`BFG_B_SUB_EN] && sub_gate;
      // Combined mode follows the main ramp too
      sub_sink.code  <= ctrl_q[`BFG_B_COMBINE] ? main_code
                                               : sub_code;
    end
  end

  // GPIO drive; pin 0 is released when it serves as PWM input
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gpio_o    <= '0;
      gpio_oe_n <= '1;
    end else begin
      gpio_o    <= gdat_q[`BFG_GPIO_N-1:0];
      gpio_oe_n <= ~gdir_q[`BFG_GPIO_N-1:0];
      if (gdir_q[`BFG_B_PWM_PIN]) begin
        gpio_oe_n[0] <= 1'b1;
      end
    end
  end

endmodule

// ---- core/bfg_defs.svh ----
`ifndef BFG_DEFS_SVH
`define BFG_DEFS_SVH

// Clock and fade timing
`define BFG_CLK_NS          5
`define BFG_FADE_SLOW_NS    1300000000
`define BFG_FADE_FAST_NS    650000000
`define BFG_FADE_STEPS      255
`define BFG_FADE_CNT_W      21

// Serial link device address (7 bits)
`define BFG_DEV_ADDR        7'h59

// Register offsets
`define BFG_A_CTRL          8'h03
`define BFG_A_MAIN_CUR      8'h04
`define BFG_A_SUB_CUR       8'h05
`define BFG_A_GPIO_DIR      8'h06
`define BFG_A_GPIO_DAT      8'h07
`define BFG_A_PWM_EN        8'h2B

// Backlight control fields
`define BFG_B_SLOPE         5
`define BFG_B_FADE_SEL      4
`define BFG_B_FADE_EN       3
`define BFG_B_COMBINE       2
`define BFG_B_MAIN_EN       1
`define BFG_B_SUB_EN        0

// PWM enable fields
`define BFG_B_PWM_MAIN      1
`define BFG_B_PWM_SUB       0

// GPIO fields
`define BFG_B_PWM_PIN       4
`define BFG_GPIO_N          3

// Reset values
`define BFG_RST_BYTE        8'h00

`endif

// ---- core/bfg_pkg.sv ----
package bfg_pkg;

  // One current sink as seen by the analog side
  typedef struct packed {
    logic       en;
    logic [7:0] code;
  } bfg_sink_t;

  // Serial link slave states
  typedef enum logic [3:0] {
    BFG_IDLE,
    BFG_ADDR,
    BFG_ADDR_ACK,
    BFG_REG,
    BFG_REG_ACK,
    BFG_WDATA,
    BFG_WDATA_ACK,
    BFG_RDATA,
    BFG_RDATA_ACK
  } bfg_link_st_t;

endpackage

// ---- core/bfg_fade.sv ----
`include "bfg_defs.svh"

module bfg_fade
  import bfg_pkg::*;
#(
  parameter int SLOW_CYC = 1,
  parameter int FAST_CYC = 1
) (
  input  wire logic       clk,       // System clock
  input  wire logic       rst_n,     // Sync reset, active low
  input  wire logic [7:0] target,    // Code written by software
  input  wire logic       ramp_en,   // Fade applies to this channel
  input  wire logic       fast,      // Short full-scale duration
  output logic      [7:0] code_q     // Applied current code
);

  logic [`BFG_FADE_CNT_W-1:0] tick_q;
  logic [`BFG_FADE_CNT_W-1:0] limit;
  logic                       tick;

  assign limit = fast ? `BFG_FADE_CNT_W'(FAST_CYC - 1)
                      : `BFG_FADE_CNT_W'(SLOW_CYC - 1);
  assign tick  = (tick_q == limit);

  // Step interval; restarts while idle so the first step is a full one
  always_ff @(posedge clk) begin
    if (!rst_n || !ramp_en || code_q == target || tick) begin
      tick_q <= '0;
    end else begin
      tick_q <= tick_q + 1'b1;
    end
  end

  // One count per interval, so time scales with the size of change
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      code_q <= `BFG_RST_BYTE;
    end else if (!ramp_en) begin
      code_q <= target;
    end else if (tick && code_q < target) begin
      code_q <= code_q + 8'h01;
    end else if (tick && code_q > target) begin
      code_q <= code_q - 8'h01;
    end
  end

endmodule

// ---- tb/bfg_checker.sv ----
`include "bfg_defs.svh"

// Port-level watcher for the backlight and GPIO block
module bfg_checker
  import bfg_pkg::*;
#(
  parameter int FADE_SLOW_CYC = 8,
  parameter int FADE_FAST_CYC = 4
) (
  input wire logic                   clk,       // Clock
  input wire logic                   rst_n,     // Sync reset
  input wire logic                   scl_i,     // Serial clock pin
  input wire logic                   sda_i,     // Serial data wire
  input wire logic                   sda_o,     // Data drive level
  input wire logic                   sda_oe_n,  // Low while pulling
  input wire logic [`BFG_GPIO_N-1:0] gpio_i,    // Pin levels
  input wire logic [`BFG_GPIO_N-1:0] gpio_o,    // Drive levels
  input wire logic [`BFG_GPIO_N-1:0] gpio_oe_n, // Low while driving
  input wire bfg_sink_t              main_sink, // Main sink
  input wire bfg_sink_t              sub_sink   // Secondary sink
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Values that stand when reset lets go
  a_reset_idle_out: assert property ($rose(rst_n) |-> sda_oe_n
    && gpio_oe_n == 3'h7 && main_sink == 9'h000 && sub_sink == 9'h000)
    else $error("outputs not idle after reset");
  // Open drain: only ever pulls low
  a_sda_open_drain: assert property (!sda_oe_n |-> !sda_o)
    else $error("serial data driven high");
  // Acknowledge starts only with the clock low
  a_ack_in_low: assert property ($fell(sda_oe_n) |-> !scl_i)
    else $error("data pulled while clock high");
  a_sda_steady_high: assert property (scl_i && $past(scl_i)
    |-> $stable(sda_oe_n))
    else $error("data moved while clock high");
  // Two sync flops keep a pin edge off the sinks for a cycle
  a_pwm_sync_delay: assert property ($changed(gpio_i[0])
    |=> $stable(main_sink.en) && $stable(sub_sink.en))
    else $error("sink enable followed pin too soon");
  // Shortest step interval is the fast count of 4
  a_main_step_gap: assert property ($changed(main_sink.code)
    |=> $stable(main_sink.code) [*3])
    else $error("main code stepped too fast");
  a_sub_step_gap: assert property ($changed(sub_sink.code)
    |=> $stable(sub_sink.code) [*3])
    else $error("secondary code stepped too fast");
  a_pins_unmoved: assert property ($changed(gpio_i[0])
    |=> $stable(gpio_oe_n) && $stable(gpio_o))
    else $error("pin 0 activity moved other pins");

  c_ack: cover property ($fell(sda_oe_n));
  c_fade: cover property ($changed(main_sink.code) && main_sink.en);
  c_gate: cover property ($fell(main_sink.en) && gpio_oe_n[0]);
endmodule

bind bfg_top bfg_checker #(
  .FADE_SLOW_CYC(FADE_SLOW_CYC),
  .FADE_FAST_CYC(FADE_FAST_CYC)
) bfg_checker_i (
  .clk, .rst_n, .scl_i, .sda_i, .sda_o, .sda_oe_n,
  .gpio_i, .gpio_o, .gpio_oe_n, .main_sink, .sub_sink
);

// ---- tb/bfg_host.sv ----
// Serial link master standing in for the host processor
module bfg_host (
  input  wire logic clk,   // Bench clock
  input  wire logic sda,   // Resolved data wire
  output logic      scl,   // Clock pin, idle high
  output logic      sda_m  // Master drive, 1 = released
);
  timeunit 1ns;
  timeprecision 100ps;
  int nacks = 0;

  // Bus idles released
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // Quarter bit; half periods are 16 clk, above 10, except the 8 clk low before a repeated start
  task automatic hp();
    repeat (8) @(posedge clk);
  endtask
  // Data moves mid-low so no edge lands beside a clock edge
  task automatic bit_io(input logic b, output logic s);
    hp();
    sda_m <= b;
    hp();
    scl <= 1'b1;
    hp();
    hp();
    s = sda;
    scl <= 1'b0;
  endtask
  task automatic start();
    sda_m <= 1'b1;
    hp();
    scl <= 1'b1;
    hp();
    sda_m <= 1'b0;
    hp();
    scl <= 1'b0;
  endtask
  task automatic stop();
    hp();
    sda_m <= 1'b0;
    hp();
    scl <= 1'b1;
    hp();
    sda_m <= 1'b1;
    hp();
  endtask
  // MSB first, then the device's acknowledge
  task automatic put(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    if (s !== 1'b0) nacks++;
  endtask
  task automatic get(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, s);
  endtask
  task automatic wr(input logic [7:0] dev, a, d);
    start();
    put(dev);
    put(a);
    put(d);
    stop();
  endtask
  // Pointer write, repeated start, one byte closed by NACK
  task automatic rd(input logic [7:0] dev, a, output logic [7:0] d);
    start();
    put(dev);
    put(a);
    start();
    put(dev | 8'h01);
    get(1'b1, d);
    stop();
  endtask
endmodule

// ---- tb/bfg_top_tb.sv ----
`include "bfg_defs.svh"

module bfg_top_tb;
  import bfg_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] W = {`BFG_DEV_ADDR, 1'b0};
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [2:0] ext = 3'h0;
  wire logic  scl, sda_m, sda_o, sda_oe_n, sda;
  wire logic [2:0] pin, gpio_o, gpio_oe_n;
  wire bfg_sink_t  main_sink, sub_sink;
  int err_total = 0;
  int compares = 0;
  int n;

  // Open-drain data wire; pins mix bench and device drive
  assign sda = sda_m & (sda_oe_n | sda_o);
  assign pin = (gpio_oe_n & ext) | (~gpio_oe_n & gpio_o);

  initial begin
    forever #2.5 clk = ~clk;
  end

  // Short fade counts keep ramps to a few hundred cycles
  bfg_top #(.FADE_SLOW_CYC(8), .FADE_FAST_CYC(4)) bfg_top_i (
    .clk, .rst_n, .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe_n,
    .gpio_i(pin), .gpio_o, .gpio_oe_n, .main_sink, .sub_sink);
  bfg_host bfg_host_i (.clk, .sda, .scl, .sda_m);

  task automatic end_of_test();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [8:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    bfg_host_i.wr(W, a, d);
  endtask
  task automatic rdc(input string what, input logic [7:0] a, e);
    logic [7:0] d;
    bfg_host_i.rd(W, a, d);
    chk(what, 9'(d), 9'(e));
  endtask
  // Bounded wait for a code; n holds the cycles spent
  task automatic wait_code(input logic sub, input logic [7:0] e);
    n = 0;
    while ((sub ? sub_sink.code : main_sink.code) !== e) begin
      @(negedge clk);
      n++;
      if (n > 400) begin
        err_total++;
        end_of_test();
      end
    end
  endtask

  task automatic t_reset();
    chk("oe", 9'(gpio_oe_n), 9'h007);
    for (int a = 3; a < 8; a++) rdc("rst", 8'(a), 8'h00);
    rdc("pwm_en", 8'h2B, 8'h00);
    wr(8'h10, 8'hA5);
    rdc("unmapped", 8'h10, 8'h00);
    chk("acks", 9'(bfg_host_i.nacks), 9'h000);
    bfg_host_i.wr(W ^ 8'h02, 8'h04, 8'hFF);
    rdc("foreign", 8'h04, 8'h00);
  endtask
  task automatic t_codes();
    wr(8'h04, 8'hFF);
    wr(8'h05, 8'h01);
    wr(8'h03, 8'h03);
    chk("main", main_sink, 9'h1FF);
    chk("sub", sub_sink, 9'h101);
    wr(8'h03, 8'h02);
    chk("sub_off", sub_sink, 9'h001);
    wr(8'h03, 8'h07);
    chk("combine", sub_sink, 9'h1FF);
    wr(8'h03, 8'h03);
    chk("own", sub_sink, 9'h101);
    wr(8'h04, 8'h00);
    chk("no_ramp", main_sink, 9'h100);
    rdc("rb", 8'h05, 8'h01);
  endtask
  // Pin 1 bench level differs from drive, so readback proves the pin
  task automatic t_gpio();
    ext <= 3'h3;
    wr(8'h06, 8'h06);
    wr(8'h07, 8'h04);
    chk("dir", 9'(gpio_oe_n), 9'h001);
    chk("out", 9'(gpio_o[2:1]), 9'h002);
    rdc("pins", 8'h07, 8'h05);
    wr(8'h06, 8'h17);
    chk("pwm_pin", 9'(gpio_oe_n), 9'h001);
    rdc("dir_rb", 8'h06, 8'h17);
  endtask
  task automatic t_pwm();
    wr(8'h2B, 8'h02);
    @(posedge clk);
    ext[0] <= 1'b0;
    repeat (6) @(negedge clk);
    chk("gate_lo", 9'({main_sink.en, sub_sink.en}), 9'h001);
    @(posedge clk);
    ext[0] <= 1'b1;
    repeat (6) @(negedge clk);
    chk("gate_hi", 9'({main_sink.en, sub_sink.en}), 9'h003);
    wr(8'h2B, 8'h01);
    @(posedge clk);
    ext[0] <= 1'b0;
    repeat (6) @(negedge clk);
    chk("gate_sub", 9'({main_sink.en, sub_sink.en}), 9'h002);
    rdc("pwm_rb", 8'h2B, 8'h01);
    wr(8'h06, 8'h07);
    chk("no_pin", 9'({main_sink.en, sub_sink.en}), 9'h003);
  endtask
  // Set-up order: slope, target, enable, then code
  task automatic t_fade();
    wr(8'h03, 8'h0A);
    wr(8'h04, 8'h10);
    chk("ramping", 9'(main_sink.code < 8'h10), 9'h001);
    wait_code(1'b0, 8'h10);
    chk("slow", 9'(n > 60 && n < 100), 9'h001);
    wr(8'h03, 8'h2A);
    wr(8'h04, 8'h00);
    wait_code(1'b0, 8'h00);
    chk("fast", 9'(n > 5 && n < 40), 9'h001);
    wr(8'h03, 8'h1B);
    wr(8'h04, 8'h20);
    chk("main_now", 9'(main_sink.code), 9'h020);
    wr(8'h05, 8'h11);
    wait_code(1'b1, 8'h11);
    chk("sub_fade", 9'(n > 60 && n < 100), 9'h001);
    wr(8'h03, 8'h0F);
    wr(8'h04, 8'h30);
    wait_code(1'b1, 8'h30);
    chk("both", 9'(n > 60 && n < 100), 9'h001);
    chk("main_end", 9'(main_sink.code), 9'h030);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_codes();
    t_gpio();
    t_pwm();
    t_fade();
    chk("nacks", 9'(bfg_host_i.nacks), 9'h003);
    end_of_test();
  end
endmodule
